// [common/crc_engine_pkg.sv]
// Shared constants, register map and state carrier of the CRC engine
package crc_engine_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFS_CRC_CONTROL_PRIMARY    = 8'h00;
  localparam logic [7:0] OFS_CRC_LENGTH_CONFIG      = 8'h04;
  localparam logic [7:0] OFS_CRC_INPUT_PAIR         = 8'h08;
  localparam logic [7:0] OFS_CRC_RESULT_ACCUMULATOR = 8'h0C;
  localparam logic [7:0] OFS_CRC_POLYNOMIAL         = 8'h10;
  localparam logic [7:0] OFS_SCAN_END_ADDRESS_UPPER = 8'h14;
  localparam logic [7:0] OFS_SCAN_END_ADDRESS_HIGH  = 8'h18;
  localparam logic [7:0] OFS_SCAN_END_ADDRESS_LOW   = 8'h1C;
  localparam logic [7:0] OFS_SCANNER_CONTROL        = 8'h20;
  localparam logic [7:0] OFS_IRQ_STATUS             = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK               = 8'h28;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int BIT_ENABLE          = 7;
  localparam int BIT_START           = 6;
  localparam int BIT_BUSY            = 5;
  localparam int BIT_ZERO_AUGMENT    = 4;
  localparam int BIT_SHIFT_DIRECTION = 1;
  localparam int BIT_FULL            = 0;
  localparam int LSB_DATA_WORD_LEN   = 4;
  localparam int LSB_POLY_LEN        = 0;
  localparam int BIT_SCAN_RUNNING    = 0;
  localparam int BIT_IRQ_DONE        = 0;
  localparam int BIT_IRQ_TAKEN       = 1;
  localparam int END_ADDR_WIDTH      = 22;
  localparam int UPPER_ADDR_WIDTH    = 6;
  localparam int CRC_WIDTH           = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SHIFT,
    ST_AUGMENT
  } crc_state_e;

  typedef struct packed {
    logic                      en;
    logic                      go;
    logic                      zero_augment_select;
    logic                      shift_dir;
    logic [3:0]                data_word_length;
    logic [3:0]                poly_length;
    logic [CRC_WIDTH-1:0]      din;
    logic                      full;
    logic [CRC_WIDTH-1:0]      poly;
    logic [CRC_WIDTH-1:0]      acc;
    logic [CRC_WIDTH-1:0]      sh;
    logic [3:0]                cnt;
    crc_state_e                st;
    logic                      aug_pend;
    logic                      scan_run;
    logic [END_ADDR_WIDTH-1:0] end_addr;
    logic [1:0]                irq_stat;
    logic [1:0]                irq_mask;
    logic                      busy_d;
    logic                      irq_out;
    logic [31:0]               hrdata;
    logic                      hreadyout;
    logic                      hresp;
    logic                      scan_ready;
    logic                      ap_valid;
    logic                      ap_write;
    logic [7:0]                ap_addr;
  } crc_state_s;

  localparam crc_state_s STATE_RST = '{hreadyout: 1'b1, st: ST_IDLE, default: '0};

endpackage : crc_engine_pkg

// [hw/crc_engine_scan_limit.sv]
// CRC engine with AHB-Lite registers, scanner input and scan end-address bound
//
// The AHB-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - Enable bit releases CRC; clear holds idle
// - Start bit runs shifter; clear stops it
// - Busy reads one while shifting or pending
// - Zero augment bit appends zeros before division
// - Control bits three and two read zero
// - Direction bit: right LSb first, left MSb
// - Full flag set until data enters shifter
// - Data length field holds bits minus one
// - Polynomial length field sizes the division
// - Scan end address is 22 bits, three bytes
// - End address writes ignored while scan runs
// - Polynomial and seed up to 16 bits
// - Check value left in readable accumulator
// - Division uses XOR feedback shift register
// - Input from scanner or software writes
// - All writable fields reset to zero
module crc_engine_scan_limit (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        scan_valid,
  input  wire logic [15:0] scan_word,
  output logic             scan_ready,
  output logic             scan_running,
  output logic      [21:0] scan_end_address,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [15:0] len_mask(input logic [3:0] poly_length);
    len_mask = 16'hFFFF >> (4'hF - poly_length);
  endfunction : len_mask

  // One step of the XOR feedback register; poly holds the taps below the top term
  function automatic logic [15:0] crc_step(input logic [15:0] acc,
                                           input logic [15:0] poly,
                                           input logic        bit_in,
                                           input logic [3:0]  poly_length,
                                           input logic        right,
                                           input logic        augment);
    logic        fb;
    logic [15:0] nx;
    fb = 1'b0;
    nx = 16'h0000;
    if (right) begin
      fb = acc[0] ^ (augment ? 1'b0 : bit_in);
      nx = acc >> 1;
      if (augment) begin
        nx[poly_length] = bit_in;
      end
    end else begin
      fb = acc[poly_length] ^ (augment ? 1'b0 : bit_in);
      nx = {acc[14:0], (augment ? bit_in : 1'b0)};
    end
    if (fb) begin
      nx = nx ^ poly;
    end
    crc_step = nx & len_mask(poly_length);
  endfunction : crc_step

  function automatic logic busy_of(input crc_engine_pkg::crc_state_s s);
    busy_of = (s.st != crc_engine_pkg::ST_IDLE) || s.full || s.aug_pend;
  endfunction : busy_of

  function automatic logic [31:0] read_word(input crc_engine_pkg::crc_state_s s, input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      crc_engine_pkg::OFS_CRC_CONTROL_PRIMARY: begin
        w[crc_engine_pkg::BIT_ENABLE]          = s.en;
        w[crc_engine_pkg::BIT_START]           = s.go;
        w[crc_engine_pkg::BIT_BUSY]            = busy_of(s);
        w[crc_engine_pkg::BIT_ZERO_AUGMENT]    = s.zero_augment_select;
        w[crc_engine_pkg::BIT_SHIFT_DIRECTION] = s.shift_dir;
        w[crc_engine_pkg::BIT_FULL]            = s.full;
      end
      crc_engine_pkg::OFS_CRC_LENGTH_CONFIG:      w[7:0] = {s.data_word_length, s.poly_length};
      crc_engine_pkg::OFS_CRC_INPUT_PAIR:         w[15:0] = s.din;
      crc_engine_pkg::OFS_CRC_RESULT_ACCUMULATOR: w[15:0] = s.acc;
      crc_engine_pkg::OFS_CRC_POLYNOMIAL:         w[15:0] = s.poly;
      crc_engine_pkg::OFS_SCAN_END_ADDRESS_UPPER: w[5:0] = s.end_addr[21:16];
      crc_engine_pkg::OFS_SCAN_END_ADDRESS_HIGH:  w[7:0] = s.end_addr[15:8];
      crc_engine_pkg::OFS_SCAN_END_ADDRESS_LOW:   w[7:0] = s.end_addr[7:0];
      crc_engine_pkg::OFS_SCANNER_CONTROL:        w[crc_engine_pkg::BIT_SCAN_RUNNING] = s.scan_run;
      crc_engine_pkg::OFS_IRQ_STATUS:             w[1:0] = s.irq_stat;
      crc_engine_pkg::OFS_IRQ_MASK:               w[1:0] = s.irq_mask;
      default:                                    w = 32'h0000_0000;
    endcase
    read_word = w;
  endfunction : read_word

  ////////////////////////////////////////////////////////////////////////////
  // State

  crc_engine_pkg::crc_state_s q_r;
  crc_engine_pkg::crc_state_s q_nxt;

  logic        ap_take;
  logic        ap_hit;
  logic        wr_en;
  logic        busy_now;
  logic        taken;
  logic        cur_bit;

  assign ap_take  = hsel && htrans[1] && hready;
  assign ap_hit   = (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'b00);
  assign wr_en    = q_r.ap_valid && q_r.ap_write;
  assign busy_now = busy_of(q_r);
  assign cur_bit  = q_r.shift_dir ? q_r.sh[0] : q_r.sh[q_r.data_word_length];

  always_comb begin
    q_nxt           = q_r;
    taken           = 1'b0;
    q_nxt.hresp     = 1'b0;
    q_nxt.hreadyout = 1'b1;

    //////////////////////////////////////////////////////////////////////////
    // Bus address phase; read data is sampled now so it stands in the data phase
    q_nxt.ap_valid = ap_take && ap_hit;
    q_nxt.ap_write = hwrite;
    q_nxt.ap_addr  = haddr[7:0];
    q_nxt.hrdata   = (ap_take && ap_hit && !hwrite) ? read_word(q_r, haddr[7:0]) : 32'h0000_0000;

    //////////////////////////////////////////////////////////////////////////
    // Shift engine
    if (!q_r.en) begin
      q_nxt.st       = crc_engine_pkg::ST_IDLE;
      q_nxt.full     = 1'b0;
      q_nxt.aug_pend = 1'b0;
      q_nxt.cnt      = 4'h0;
      q_nxt.sh       = crc_engine_pkg::RST_WORD;
    end else begin
      case (q_r.st)
        crc_engine_pkg::ST_IDLE: begin
          if (q_r.go && q_r.full) begin
            q_nxt.sh   = q_r.din;
            q_nxt.full = 1'b0;
            q_nxt.cnt  = 4'h0;
            q_nxt.st   = crc_engine_pkg::ST_SHIFT;
            taken      = 1'b1;
          end else if (q_r.go && q_r.aug_pend) begin
            q_nxt.cnt = 4'h0;
            q_nxt.st  = crc_engine_pkg::ST_AUGMENT;
          end
        end
        crc_engine_pkg::ST_SHIFT: begin
          if (!q_r.go) begin
            q_nxt.st  = crc_engine_pkg::ST_IDLE;
            q_nxt.cnt = 4'h0;
          end else begin
            q_nxt.acc = crc_step(q_r.acc, q_r.poly, cur_bit, q_r.poly_length, q_r.shift_dir, q_r.zero_augment_select);
            q_nxt.sh  = q_r.shift_dir ? (q_r.sh >> 1) : (q_r.sh << 1);
            if (q_r.zero_augment_select) begin
              q_nxt.aug_pend = 1'b1;
            end
            if (q_r.cnt == q_r.data_word_length) begin
              if (q_r.full) begin
                q_nxt.sh   = q_r.din;
                q_nxt.full = 1'b0;
                q_nxt.cnt  = 4'h0;
                taken      = 1'b1;
              end else begin
                q_nxt.st  = crc_engine_pkg::ST_IDLE;
                q_nxt.cnt = 4'h0;
              end
            end else begin
              q_nxt.cnt = q_r.cnt + 4'h1;
            end
          end
        end
        crc_engine_pkg::ST_AUGMENT: begin
          if (!q_r.go) begin
            q_nxt.st  = crc_engine_pkg::ST_IDLE;
            q_nxt.cnt = 4'h0;
          end else begin
            // Zeros run out the register so the remainder is complete
            q_nxt.acc = crc_step(q_r.acc, q_r.poly, 1'b0, q_r.poly_length, q_r.shift_dir, 1'b1);
            if (q_r.cnt == q_r.poly_length) begin
              q_nxt.st       = crc_engine_pkg::ST_IDLE;
              q_nxt.aug_pend = 1'b0;
              q_nxt.cnt      = 4'h0;
            end else begin
              q_nxt.cnt = q_r.cnt + 4'h1;
            end
          end
        end
        default: begin
          q_nxt.st = crc_engine_pkg::ST_IDLE;
        end
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Scanner word accepted into the input pair
    if (q_r.scan_ready && scan_valid && q_r.en) begin
      q_nxt.din  = scan_word;
      q_nxt.full = 1'b1;
    end

    //////////////////////////////////////////////////////////////////////////
    // Bus data phase writes; a write lands after the engine so software wins
    if (wr_en) begin
      case (q_r.ap_addr)
        crc_engine_pkg::OFS_CRC_CONTROL_PRIMARY: begin
          // Busy, full and bits three and two are not writable
          q_nxt.en        = hwdata[crc_engine_pkg::BIT_ENABLE];
          q_nxt.go        = hwdata[crc_engine_pkg::BIT_START];
          q_nxt.zero_augment_select      = hwdata[crc_engine_pkg::BIT_ZERO_AUGMENT];
          q_nxt.shift_dir = hwdata[crc_engine_pkg::BIT_SHIFT_DIRECTION];
        end
        crc_engine_pkg::OFS_CRC_LENGTH_CONFIG: begin
          q_nxt.data_word_length = hwdata[crc_engine_pkg::LSB_DATA_WORD_LEN +: 4];
          q_nxt.poly_length = hwdata[crc_engine_pkg::LSB_POLY_LEN +: 4];
        end
        crc_engine_pkg::OFS_CRC_INPUT_PAIR: begin
          // The scanner owns the input while it runs
          if (!q_r.scan_run && q_r.en) begin
            q_nxt.din  = hwdata[15:0];
            q_nxt.full = 1'b1;
          end
        end
        crc_engine_pkg::OFS_CRC_RESULT_ACCUMULATOR: q_nxt.acc  = hwdata[15:0];
        crc_engine_pkg::OFS_CRC_POLYNOMIAL:         q_nxt.poly = hwdata[15:0];
        crc_engine_pkg::OFS_SCAN_END_ADDRESS_UPPER: begin
          if (!q_r.scan_run) begin
            q_nxt.end_addr[21:16] = hwdata[5:0];
          end
        end
        crc_engine_pkg::OFS_SCAN_END_ADDRESS_HIGH: begin
          if (!q_r.scan_run) begin
            q_nxt.end_addr[15:8] = hwdata[7:0];
          end
        end
        crc_engine_pkg::OFS_SCAN_END_ADDRESS_LOW: begin
          if (!q_r.scan_run) begin
            q_nxt.end_addr[7:0] = hwdata[7:0];
          end
        end
        crc_engine_pkg::OFS_SCANNER_CONTROL: q_nxt.scan_run = hwdata[crc_engine_pkg::BIT_SCAN_RUNNING];
        crc_engine_pkg::OFS_IRQ_STATUS:      q_nxt.irq_stat = q_r.irq_stat & ~hwdata[1:0];
        crc_engine_pkg::OFS_IRQ_MASK:        q_nxt.irq_mask = hwdata[1:0];
        default: begin
        end
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Events; setting after the clear means a coincident event is kept
    q_nxt.busy_d = busy_now;
    if (q_r.busy_d && !busy_now) begin
      q_nxt.irq_stat[crc_engine_pkg::BIT_IRQ_DONE] = 1'b1;
    end
    if (taken) begin
      q_nxt.irq_stat[crc_engine_pkg::BIT_IRQ_TAKEN] = 1'b1;
    end
    q_nxt.irq_out    = |(q_r.irq_stat & q_r.irq_mask);
    q_nxt.scan_ready = q_nxt.en && q_nxt.scan_run && !q_nxt.full;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      q_r <= crc_engine_pkg::STATE_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign hrdata           = q_r.hrdata;
  assign hreadyout        = q_r.hreadyout;
  assign hresp            = q_r.hresp;
  assign scan_ready       = q_r.scan_ready;
  assign scan_running     = q_r.scan_run;
  assign scan_end_address = q_r.end_addr;
  assign irq              = q_r.irq_out;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  logic [31:0] ctrl_view;
  assign ctrl_view = read_word(q_r, crc_engine_pkg::OFS_CRC_CONTROL_PRIMARY);

  chk_disable_idle: assert property (!q_r.en |=> (q_r.st == crc_engine_pkg::ST_IDLE) && !q_r.full)
    else $error("engine not idle while disabled");

  chk_stop_shifter: assert property (!q_r.go && q_r.en |=> q_r.st == crc_engine_pkg::ST_IDLE)
    else $error("shifter kept running after start cleared");

  chk_busy_clear: assert property ($fell(ctrl_view[crc_engine_pkg::BIT_BUSY]) |->
                                   !q_r.full && (q_r.st == crc_engine_pkg::ST_IDLE) && !ctrl_view[0])
    else $error("busy dropped with work left");

  chk_reserved_zero: assert property (ctrl_view[3:2] == 2'b00)
    else $error("unimplemented control bits not zero");

  chk_word_length: assert property ((q_r.st == crc_engine_pkg::ST_SHIFT) && q_r.en && q_r.go &&
                                    (q_r.cnt == q_r.data_word_length) |=> q_r.cnt == 4'h0)
    else $error("word length count wrong");

  chk_full_consume: assert property ((q_r.st == crc_engine_pkg::ST_IDLE) && q_r.en && q_r.go && q_r.full &&
                                     !wr_en |=> (q_r.st == crc_engine_pkg::ST_SHIFT) && !q_r.full)
    else $error("full data not moved into shifter");

  chk_scan_lock: assert property (wr_en && q_r.scan_run && (q_r.ap_addr >= crc_engine_pkg::OFS_SCAN_END_ADDRESS_UPPER) &&
                                  (q_r.ap_addr <= crc_engine_pkg::OFS_SCAN_END_ADDRESS_LOW) |=> $stable(q_r.end_addr))
    else $error("end address changed while scan running");

  chk_upper_width: assert property (q_r.end_addr[21:16] == scan_end_address[21:16])
    else $error("upper end address bits lost");

  chk_irq_level: assert property (!(|(q_r.irq_stat & q_r.irq_mask)) |=> !irq)
    else $error("interrupt high with nothing unmasked");

  chk_done_sticky: assert property ($fell(ctrl_view[crc_engine_pkg::BIT_BUSY]) |=> q_r.irq_stat[0])
    else $error("done event lost");

  chk_acc_width: assert property ((q_r.st == crc_engine_pkg::ST_SHIFT) && q_r.en && q_r.go && !wr_en |=>
                                  (q_r.acc & ~len_mask(q_r.poly_length)) == 16'h0000)
    else $error("accumulator bits above polynomial length set");

endmodule : crc_engine_scan_limit

// [sim/scan_source_model.sv]
// Scanner word source standing at the far side of the CRC engine
`timescale 1ns/1ps
module scan_source_model (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        scan_ready,
  output logic             scan_valid,
  output logic      [15:0] scan_word
);
  logic [15:0] q[$];
  int          stall;

  task automatic push(input logic [15:0] w);
    q.push_back(w);
  endtask : push

  function automatic logic is_drained();
    return (q.size() == 0) && (scan_valid !== 1'b1);
  endfunction : is_drained

  // Random stalls; an idle word line toggles so a stale word is never mistaken for a fresh one
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      scan_valid <= 1'b0;
      scan_word  <= 16'h0000;
      stall      <= 0;
    end else if (scan_valid && scan_ready) begin
      scan_valid <= 1'b0;
      scan_word  <= ~scan_word;
      stall      <= $urandom_range(3, 0);
    end else if (!scan_valid && stall != 0) begin
      stall     <= stall - 1;
      scan_word <= ~scan_word;
    end else if (!scan_valid && q.size() != 0) begin
      scan_valid <= 1'b1;
      scan_word  <= q.pop_front();
    end else if (!scan_valid) begin
      scan_word <= ~scan_word;
    end
  end
endmodule : scan_source_model

// [sim/crc_engine_scan_limit_tb_top.sv]
// Self-checking bench of the CRC engine: AHB-Lite master, reference CRC and scanner source
`timescale 1ns/1ps
module crc_engine_scan_limit_tb_top;
  typedef struct { string name; logic [31:0] val; logic [31:0] msk; } note_s;
  localparam logic [7:0] A_CTL = crc_engine_pkg::OFS_CRC_CONTROL_PRIMARY;
  localparam logic [7:0] A_LEN = crc_engine_pkg::OFS_CRC_LENGTH_CONFIG;
  localparam logic [7:0] A_DIN = crc_engine_pkg::OFS_CRC_INPUT_PAIR;
  localparam logic [7:0] A_ACC = crc_engine_pkg::OFS_CRC_RESULT_ACCUMULATOR;
  localparam logic [7:0] A_POL = crc_engine_pkg::OFS_CRC_POLYNOMIAL;
  localparam logic [7:0] A_UP  = crc_engine_pkg::OFS_SCAN_END_ADDRESS_UPPER;
  localparam logic [7:0] A_HI  = crc_engine_pkg::OFS_SCAN_END_ADDRESS_HIGH;
  localparam logic [7:0] A_LO  = crc_engine_pkg::OFS_SCAN_END_ADDRESS_LOW;
  localparam logic [7:0] A_SC  = crc_engine_pkg::OFS_SCANNER_CONTROL;
  localparam logic [7:0] A_IST = crc_engine_pkg::OFS_IRQ_STATUS;
  localparam logic [7:0] A_IMK = crc_engine_pkg::OFS_IRQ_MASK;
  logic        ref_clk, reset, hsel, hwrite, want, ph_rd;
  logic        hreadyout, hresp, scan_valid, scan_ready, scan_running, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] scan_word;
  logic [21:0] scan_end_address;
  note_s       notes[$];
  int          fails, samples_checked;

  crc_engine_scan_limit dut (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .scan_valid(scan_valid), .scan_word(scan_word),
    .scan_ready(scan_ready), .scan_running(scan_running), .scan_end_address(scan_end_address), .irq(irq));
  scan_source_model u_scan (.ref_clk(ref_clk), .reset(reset), .scan_ready(scan_ready),
    .scan_valid(scan_valid), .scan_word(scan_word));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Read data is judged here, in the data phase, against the oldest note
  always @(posedge ref_clk) begin
    if (ph_rd === 1'b1) begin
      check(notes[0].name, notes[0].val & notes[0].msk, hrdata & notes[0].msk);
      void'(notes.pop_front());
    end
    ph_rd <= hsel && htrans[1] && hreadyout && !hwrite && want;
  end

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic chk,
                     input logic [31:0] exp, input logic [31:0] m);
    if (chk) notes.push_back('{$sformatf("reg_%h", a), exp, m});
    @(posedge ref_clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    want   <= chk;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 1'b0, 32'h0, 32'h0);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    bus(1'b0, a, 32'h0, 1'b1, exp, m);
  endtask : rdchk

  // Poll a control bit; a bit that never settles is reported rather than waited on forever
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      bus(1'b0, A_CTL, 32'h0, 1'b0, 32'h0, 32'h0);
      n++;
    end while (rd[b] !== v && n < 300);
    if (n >= 300) check("poll", 32'(v), 32'(rd[b]));
  endtask : poll

  function automatic logic [15:0] step(input logic [15:0] acc, input logic [15:0] p, input logic b,
                                       input logic [3:0] pl, input logic r, input logic aug);
    logic [15:0] m, nx;
    logic        fb;
    m = 16'hFFFF >> (15 - pl);
    if (r) begin
      fb = aug ? acc[0] : acc[0] ^ b;
      nx = acc >> 1;
      if (aug) nx[pl] = b;
    end else begin
      fb = aug ? acc[pl] : acc[pl] ^ b;
      nx = {acc[14:0], aug & b};
    end
    return (fb ? nx ^ p : nx) & m;
  endfunction : step
  ////////////////////////////////////////////////////////////////////////////
  task automatic crc_case(input int i);
    logic [3:0]  dl, pl;
    logic [15:0] p, acc, msk;
    logic [15:0] w[2];
    logic [7:0]  c;
    logic        r, a;
    int          nw;
    r = i[0];
    a = i[1];
    dl = 4'($urandom);
    pl = 4'($urandom);
    msk = 16'hFFFF >> (15 - pl);
    p = 16'($urandom) & msk;
    acc = 16'($urandom) & msk;
    nw = a ? 1 : 2;
    c = {3'b100, a, 2'b00, r, 1'b0};
    wr(A_CTL, 32'h0);
    wr(A_LEN, {24'h0, dl, pl});
    rdchk(A_LEN, {24'h0, dl, pl}, 32'hFFFFFFFF);
    wr(A_POL, {16'h0, p});
    wr(A_ACC, {16'h0, acc});
    wr(A_CTL, {24'h0, c});
    for (int k = 0; k < nw; k++) begin
      w[k] = 16'($urandom);
      for (int j = 0; j <= dl; j++) acc = step(acc, p, w[k][r ? j : dl - j], pl, r, a);
    end
    if (a) for (int j = 0; j <= pl; j++) acc = step(acc, p, 1'b0, pl, r, 1'b1);
    wr(A_DIN, {16'h0, w[0]});
    rdchk(A_CTL, {24'h0, c | 8'h21}, 32'hFFFFFFFF);
    wr(A_CTL, {24'h0, c | 8'h40});
    if (nw == 2) begin
      poll(0, 1'b0);
      wr(A_DIN, {16'h0, w[1]});
    end
    poll(5, 1'b0);
    rdchk(A_ACC, {16'h0, acc}, 32'hFFFFFFFF);
  endtask : crc_case
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] acc, w;
    reset = 1'b1;
    {hsel, hwrite, want, ph_rd} = 4'h0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    hsize = 3'b010;
    void'($urandom(84353));
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    rdchk(A_CTL, 32'h0, 32'hFFFFFFFF);
    rdchk(A_LEN, 32'h0, 32'hFFFFFFFF);
    rdchk(A_UP, 32'h0, 32'hFFFFFFFF);
    rdchk(A_HI, 32'h0, 32'hFFFFFFFF);
    rdchk(A_LO, 32'h0, 32'hFFFFFFFF);
    rdchk(8'hFC, 32'h0, 32'hFFFFFFFF);
    wr(A_CTL, 32'hFF);
    rdchk(A_CTL, 32'hD2, 32'hFFFFFFFF);
    wr(A_CTL, 32'h80);
    wr(A_DIN, 32'h1234);
    rdchk(A_CTL, 32'hA1, 32'hFFFFFFFF);
    wr(A_CTL, 32'h0);
    wr(A_DIN, 32'h1234);
    rdchk(A_CTL, 32'h0, 32'hFFFFFFFF);
    for (int i = 0; i < 8; i++) crc_case(i);
    // Disable first so the scanner cannot feed words under the previous case's modes
    wr(A_CTL, 32'h0);
    wr(A_IST, 32'h3);
    wr(A_LEN, 32'hFF);
    wr(A_POL, 32'h1021);
    wr(A_ACC, 32'hFFFF);
    wr(A_SC, 32'h1);
    @(negedge ref_clk);
    check("scan_running", 32'h1, 32'(scan_running));
    acc = 16'hFFFF;
    for (int k = 0; k < 3; k++) begin
      w = 16'($urandom);
      u_scan.push(w);
      for (int j = 15; j >= 0; j--) acc = step(acc, 16'h1021, w[j], 4'hF, 1'b0, 1'b0);
    end
    wr(A_CTL, 32'hC0);
    while (!u_scan.is_drained()) @(posedge ref_clk);
    poll(5, 1'b0);
    rdchk(A_ACC, {16'h0, acc}, 32'hFFFFFFFF);
    wr(A_UP, 32'h3F);
    wr(A_HI, 32'hA5);
    wr(A_LO, 32'h5A);
    @(negedge ref_clk);
    check("scan_end_address", 32'h0, 32'(scan_end_address));
    rdchk(A_HI, 32'h0, 32'hFFFFFFFF);
    wr(A_SC, 32'h0);
    wr(A_UP, 32'h3F);
    wr(A_HI, 32'hA5);
    wr(A_LO, 32'h5A);
    repeat (2) @(posedge ref_clk);
    check("scan_end_address", 32'h3FA55A, 32'(scan_end_address));
    rdchk(A_UP, 32'h3F, 32'hFFFFFFFF);
    rdchk(A_LO, 32'h5A, 32'hFFFFFFFF);
    rdchk(A_IST, 32'h3, 32'hFFFFFFFF);
    wr(A_IMK, 32'h1);
    repeat (2) @(posedge ref_clk);
    check("irq", 32'h1, 32'(irq));
    wr(A_IST, 32'h1);
    repeat (2) @(posedge ref_clk);
    check("irq", 32'h0, 32'(irq));
    rdchk(A_IST, 32'h2, 32'hFFFFFFFF);
    wr(A_IMK, 32'h2);
    repeat (2) @(posedge ref_clk);
    check("irq", 32'h1, 32'(irq));
    wr(A_IMK, 32'h0);
    repeat (2) @(posedge ref_clk);
    check("irq", 32'h0, 32'(irq));
    summarize();
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    summarize();
  end
endmodule : crc_engine_scan_limit_tb_top
